/* core/pcsu_pkg.sv */
// package for the parameter command and security unit
package pcsu_pkg;
	localparam int unsigned CW = 32;
	// action codes
	localparam logic [31:0] ACT_NONE     = 32'h0000_0000;
	localparam logic [31:0] ACT_MODE_50  = 32'h0000_04e5; // 1253
	localparam logic [31:0] ACT_MODE_60  = 32'h0000_04e6; // 1254
	localparam logic [31:0] ACT_SAVE     = 32'h0000_03e8; // 1000
	localparam logic [31:0] ACT_SAVE_UV  = 32'h0000_03e9; // 1001
	localparam logic [31:0] ACT_DEF_50   = 32'h0000_04d1; // 1233
	localparam logic [31:0] ACT_DEF_60   = 32'h0000_04dc; // 1244
	localparam logic [31:0] ACT_SHOW_ND  = 32'h0000_2ee0; // 12000
	localparam logic [31:0] RST_REQ_CODE = 32'h0000_0064; // 100
	localparam logic [31:0] CODE_MAX     = 32'h7fff_ffff;
	// operating mode encodings
	localparam logic [1:0] MODE_OPEN_LOOP = 2'h1;
	localparam logic [1:0] MODE_RFI       = 2'h2; // rotor_flux_induction_mode
	localparam logic [1:0] MODE_RFS       = 2'h3; // rotor_flux_synchronous_mode
	// security levels
	localparam logic [2:0] LVL_BASIC     = 3'h0;
	localparam logic [2:0] LVL_ALL       = 3'h1;
	localparam logic [2:0] LVL_RO_BASIC  = 3'h2;
	localparam logic [2:0] LVL_RO_ALL    = 3'h3;
	localparam logic [2:0] LVL_STATUS    = 3'h4;
	localparam logic [2:0] LVL_NO_ACCESS = 3'h5;
	// register byte offsets
	localparam logic [7:0] OFF_ACTION   = 8'h00;
	localparam logic [7:0] OFF_MODE     = 8'h04;
	localparam logic [7:0] OFF_LEVEL    = 8'h08;
	localparam logic [7:0] OFF_CODE     = 8'h0c;
	localparam logic [7:0] OFF_UNLOCK   = 8'h10;
	localparam logic [7:0] OFF_RSTREQ   = 8'h14;
	localparam logic [7:0] OFF_CTRL     = 8'h18;
	localparam logic [7:0] OFF_STATUS   = 8'h1c;
	localparam logic [7:0] OFF_ACCESS   = 8'h20;
	// ctrl bits
	localparam int unsigned CTRL_ENABLE = 0;
	localparam int unsigned CTRL_UV     = 1;
	localparam int unsigned CTRL_SERIAL = 2;
	localparam int unsigned CTRL_EDIT   = 3;
	localparam int unsigned CTRL_BASIC  = 4;
	localparam int unsigned CTRL_ADV    = 5;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  HSIZE_WORD = 3'h2;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_EXEC   = 3'b010,
		ST_CLEAR  = 3'b100
	} pcsu_state_t;
endpackage

/* core/pcsu_top.sv */
// parameter command interpreter and access security, ahb-lite slave
// Functional notes
// - mode change restores all defaults, security kept
// - mode change and restore only when disabled
// - 1253/1254 arm mode change 50/60 Hz
// - serial mode codes 1,2,3
// - pending action runs on any drive reset
// - mode defaults load only if mode changed
// - basic edit saved on leaving edit mode
// - advanced edits need 1000 plus reset
// - under-voltage save needs 1001
// - 1233/1244 restore and save defaults
// - levels 0-3 set visibility and writability
// - levels 4,5 status only; 5 blocks comms except ctrl writes
// - reset state basic menu, security open
// - active code blocks writes, level changeable
// - code 1 to max, active at reset
// - active code reads back as zero
// - unlock compares code, wrong code rejected
// - writing 0 after unlock disables security
// - 12000 filters non-default immediately, 0 cancels
`timescale 1ns/100ps
`default_nettype none
module pcsu_top
	import pcsu_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        enable_pin,
	input  wire logic        reset_pin,
	input  wire logic        reset_key,
	output logic             load_defaults,
	output logic             defaults_60hz,
	output logic             save_params,
	output logic      [1:0]  op_mode,
	output logic             filter_nondefault,
	output logic             unlock_fail
);
	// pin synchronisers, three stages, agree on last two
	logic [2:0] en_s_q, rp_s_q, rk_s_q;
	logic       rp_q, rk_q, en_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_s_q <= 3'h0;
			rp_s_q <= 3'h0;
			rk_s_q <= 3'h0;
			rp_q   <= 1'b0;
			rk_q   <= 1'b0;
			en_q   <= 1'b0;
		end else begin
			en_s_q <= {en_s_q[1:0], enable_pin};
			rp_s_q <= {rp_s_q[1:0], reset_pin};
			rk_s_q <= {rk_s_q[1:0], reset_key};
			if (rp_s_q[2] == rp_s_q[1]) rp_q <= rp_s_q[1];
			if (rk_s_q[2] == rk_s_q[1]) rk_q <= rk_s_q[1];
			if (en_s_q[2] == en_s_q[1]) en_q <= en_s_q[1];
		end
	end
	wire rp_stable = (rp_s_q[2] == rp_s_q[1]);
	wire rk_stable = (rk_s_q[2] == rk_s_q[1]);
	wire en_level  = en_q; // enable level changes only once stages agree

	// bus address phase capture
	logic        wr_q, rd_q;
	logic [7:0]  addr_q;
	wire         take = hsel & hready & htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_q   <= take & hwrite;
			rd_q   <= take & ~hwrite;
			addr_q <= haddr[7:0];
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// write strobes
	wire w_action = wr_q && (addr_q == OFF_ACTION);
	wire w_mode   = wr_q && (addr_q == OFF_MODE);
	wire w_level  = wr_q && (addr_q == OFF_LEVEL);
	wire w_code   = wr_q && (addr_q == OFF_CODE);
	wire w_unlock = wr_q && (addr_q == OFF_UNLOCK);
	wire w_rstreq = wr_q && (addr_q == OFF_RSTREQ);
	wire w_ctrl   = wr_q && (addr_q == OFF_CTRL);

	// state registers
	logic [31:0] action_code_param_q;
	logic [1:0]  mode_q, mode_ref_q;
	logic [2:0]  level_q;
	logic [31:0] code_q;
	logic        code_active_q, unlocked_q, filter_q;
	logic [5:0]  ctrl_q;
	logic        fail_q, pend_code_q;
	pcsu_state_t st_q;

	wire serial     = ctrl_q[CTRL_SERIAL];
	wire drive_off  = ~en_level | ~ctrl_q[CTRL_ENABLE];
	wire uv         = ctrl_q[CTRL_UV];
	// level 5 blocks serial access, except writes to the ctrl register
	wire comms_lock = serial && (level_q == LVL_NO_ACCESS);
	// security code blocks writes unless unlocked
	wire sec_block  = code_active_q & ~unlocked_q;

	// visibility and write permission per level
	function automatic logic [3:0] access_of(input logic [2:0] lvl, input logic blk);
		logic vb, va, wb, wa;
		vb = 1'b0;
		va = 1'b0;
		wb = 1'b0;
		wa = 1'b0;
		case (lvl)
			LVL_BASIC: begin
				vb = 1'b1;
				wb = ~blk;
			end
			LVL_ALL: begin
				vb = 1'b1;
				va = 1'b1;
				wb = ~blk;
				wa = ~blk;
			end
			LVL_RO_BASIC: vb = 1'b1;
			LVL_RO_ALL: begin
				vb = 1'b1;
				va = 1'b1;
			end
			default: vb = 1'b0;
		endcase
		return {wa, wb, va, vb};
	endfunction
	wire [3:0] acc = access_of(level_q, sec_block);
	wire       wr_ok = acc[2] & ~comms_lock;

	// drive reset event from key, pin toggle or serial request
	// any reset source triggers pending action
	wire rst_evt = (rk_stable & rk_s_q[1] & ~rk_q) |
	               (rp_stable & (rp_s_q[1] != rp_q)) |
	               (w_rstreq & (hwdata == RST_REQ_CODE) & ~comms_lock);

	// decode of pending action
	// mode codes for 50 and 60 Hz
	wire is_mode = (action_code_param_q == ACT_MODE_50) | (action_code_param_q == ACT_MODE_60);
	wire is_def  = (action_code_param_q == ACT_DEF_50) | (action_code_param_q == ACT_DEF_60);
	// under voltage picks the save code
	wire is_save = uv ? (action_code_param_q == ACT_SAVE_UV)
	                  : (action_code_param_q == ACT_SAVE);
	wire hz60    = (action_code_param_q == ACT_MODE_60) | (action_code_param_q == ACT_DEF_60);
	wire mode_ok = (hwdata[1:0] != 2'h0) && (hwdata[31:2] == 30'h0);
	wire code_ok = (hwdata != 32'h0) && (hwdata <= CODE_MAX);

	// command execution state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q          <= ST_IDLE;
			load_defaults <= 1'b0;
			defaults_60hz <= 1'b0;
			save_params   <= 1'b0;
			mode_ref_q    <= MODE_OPEN_LOOP;
		end else begin
			load_defaults <= 1'b0;
			save_params   <= 1'b0;
			case (st_q)
				ST_IDLE: if (rst_evt) st_q <= ST_EXEC;
				ST_EXEC: begin
					st_q <= ST_CLEAR;
					if (drive_off) begin
						if (is_mode && (mode_q != mode_ref_q)) begin
							load_defaults <= 1'b1;
							defaults_60hz <= hz60;
							mode_ref_q    <= mode_q;
						end
						if (is_def) begin
							load_defaults <= 1'b1;
							defaults_60hz <= hz60;
							save_params   <= 1'b1;
						end
					end
					if (is_save) save_params <= 1'b1;
				end
				ST_CLEAR: st_q <= ST_IDLE;
				default: st_q <= ST_IDLE;
			endcase
			// basic edit saved on leaving edit mode
			if (w_ctrl && ctrl_q[CTRL_EDIT] && !hwdata[CTRL_EDIT] && ctrl_q[CTRL_BASIC])
				save_params <= 1'b1;
		end
	end

	// parameter and security registers
	// reset to basic level, security open
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			action_code_param_q <= ACT_NONE;
			mode_q              <= MODE_OPEN_LOOP;
			level_q             <= LVL_BASIC;
			code_q              <= 32'h0;
			code_active_q       <= 1'b0;
			unlocked_q          <= 1'b0;
			filter_q            <= 1'b0;
			ctrl_q              <= 6'h0;
			fail_q              <= 1'b0;
			pend_code_q         <= 1'b0;
		end else begin
			if (w_ctrl) ctrl_q <= hwdata[5:0];
			// a fresh write wins over the clear in the same cycle
			if (w_action && wr_ok) begin
				action_code_param_q <= hwdata;
				if (hwdata == ACT_SHOW_ND) filter_q <= 1'b1;
				else if (hwdata == ACT_NONE) filter_q <= 1'b0;
			end else if (st_q == ST_CLEAR) begin
				action_code_param_q <= ACT_NONE;
			end
			if (w_mode && wr_ok && mode_ok) mode_q <= hwdata[1:0];
			// level writable even when code active
			if (w_level && !comms_lock && (hwdata[31:3] == 29'h0) && (hwdata[2:0] <= LVL_NO_ACCESS))
				level_q <= hwdata[2:0];
			if (w_code && wr_ok) begin
				if (hwdata == 32'h0) begin
					code_q        <= 32'h0;
					code_active_q <= 1'b0;
					pend_code_q   <= 1'b0;
				end else if (code_ok) begin
					// code range, armed for next reset
					code_q      <= hwdata;
					pend_code_q <= 1'b1;
				end
			end
			if (st_q == ST_EXEC) begin
				if (pend_code_q) code_active_q <= 1'b1;
				if (!(w_code && wr_ok && code_ok)) pend_code_q <= 1'b0;
				unlocked_q  <= 1'b0;
			end
			if (w_unlock && code_active_q && !comms_lock) begin
				unlocked_q <= (hwdata == code_q);
				fail_q     <= (hwdata != code_q);
			end else if (w_ctrl) fail_q <= 1'b0;
		end
	end

	// read mux
	// active code reads as zero
	wire [31:0] code_rd = code_active_q ? 32'h0 : code_q;
	wire [31:0] status_w = {24'h0, st_q != ST_IDLE, fail_q, filter_q, unlocked_q,
	                        code_active_q, pend_code_q, drive_off, uv};
	wire [31:0] rd_mux =
		comms_lock                ? 32'h0 :
		(addr_q == OFF_ACTION)    ? action_code_param_q :
		(addr_q == OFF_MODE)      ? {30'h0, mode_q} :
		(addr_q == OFF_LEVEL)     ? {29'h0, level_q} :
		(addr_q == OFF_CODE)      ? code_rd :
		(addr_q == OFF_CTRL)      ? {26'h0, ctrl_q} :
		(addr_q == OFF_STATUS)    ? status_w :
		(addr_q == OFF_ACCESS)    ? {28'h0, acc} : 32'h0;
	assign hrdata            = rd_q ? rd_mux : 32'h0;
	assign op_mode           = mode_q;
	assign filter_nondefault = filter_q;
	assign unlock_fail       = fail_q;

	// checks
	property p_clear;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == ST_CLEAR && !(w_action && wr_ok)) |=> (action_code_param_q == ACT_NONE);
	endproperty
	a_clear: assert property (p_clear) else $error("command not cleared");
	property p_def_off;
		@(posedge hclk) disable iff (!hresetn)
		load_defaults |-> $past(drive_off);
	endproperty
	a_def_off: assert property (p_def_off) else $error("defaults while enabled");
	property p_exec;
		@(posedge hclk) disable iff (!hresetn)
		(rst_evt && st_q == ST_IDLE) |=> (st_q == ST_EXEC) ##1 (st_q == ST_CLEAR);
	endproperty
	a_exec: assert property (p_exec) else $error("reset did not run action");
	property p_hide;
		@(posedge hclk) disable iff (!hresetn)
		(rd_q && addr_q == OFF_CODE && code_active_q) |-> (hrdata == 32'h0);
	endproperty
	a_hide: assert property (p_hide) else $error("code visible");
	property p_block;
		@(posedge hclk) disable iff (!hresetn)
		(code_active_q && !unlocked_q) |-> (acc[3:2] == 2'b00);
	endproperty
	a_block: assert property (p_block) else $error("write allowed under code");
	property p_lvl4;
		@(posedge hclk) disable iff (!hresetn)
		(level_q >= LVL_STATUS) |-> (acc == 4'h0);
	endproperty
	a_lvl4: assert property (p_lvl4) else $error("status level shows menus");
	property p_filter;
		@(posedge hclk) disable iff (!hresetn)
		(w_action && wr_ok && hwdata == ACT_SHOW_ND && st_q != ST_CLEAR) |=> filter_q;
	endproperty
	a_filter: assert property (p_filter) else $error("filter not immediate");
	property p_uvsave;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == ST_EXEC && uv && action_code_param_q == ACT_SAVE && !w_ctrl) |=> !save_params;
	endproperty
	a_uvsave: assert property (p_uvsave) else $error("1000 saved in undervoltage");
	property p_mode_same;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == ST_EXEC && is_mode && mode_q == mode_ref_q) |=> !load_defaults;
	endproperty
	a_mode_same: assert property (p_mode_same) else $error("defaults on same mode");
	property p_mode_load;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == ST_EXEC && drive_off && is_mode && mode_q != mode_ref_q) |=> load_defaults;
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("mode change gave no defaults");
	property p_restore;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == ST_EXEC && drive_off && is_def) |=> (load_defaults && save_params);
	endproperty
	a_restore: assert property (p_restore) else $error("restore not loaded and saved");
	property p_save;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == ST_EXEC && is_save) |=> save_params;
	endproperty
	a_save: assert property (p_save) else $error("save code did not save");
	property p_comms;
		@(posedge hclk) disable iff (!hresetn)
		(rd_q && comms_lock) |-> (hrdata == 32'h0);
	endproperty
	a_comms: assert property (p_comms) else $error("serial read under no access");
	property p_arm;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == ST_EXEC && pend_code_q) |=> code_active_q;
	endproperty
	a_arm: assert property (p_arm) else $error("code not active after reset");
	property p_wrong;
		@(posedge hclk) disable iff (!hresetn)
		(w_unlock && code_active_q && !comms_lock && hwdata != code_q) |=> (fail_q && !unlocked_q);
	endproperty
	a_wrong: assert property (p_wrong) else $error("wrong code not rejected");
	property p_level;
		@(posedge hclk) disable iff (!hresetn)
		(w_level && !comms_lock && hwdata <= 32'(LVL_NO_ACCESS)) |=> (32'(level_q) == $past(hwdata));
	endproperty
	a_level: assert property (p_level) else $error("level write not taken");
	property p_filter_off;
		@(posedge hclk) disable iff (!hresetn)
		(w_action && wr_ok && hwdata == ACT_NONE) |=> !filter_q;
	endproperty
	a_filter_off: assert property (p_filter_off) else $error("filter not cancelled");
	c_save: cover property (@(posedge hclk) disable iff (!hresetn) save_params);
	c_def: cover property (@(posedge hclk) disable iff (!hresetn) load_defaults);
	c_unlock: cover property (@(posedge hclk) disable iff (!hresetn) $rose(unlocked_q));
	c_lock: cover property (@(posedge hclk) disable iff (!hresetn) rd_q && comms_lock);
	c_fail: cover property (@(posedge hclk) disable iff (!hresetn) $rose(fail_q));
endmodule // pcsu_top
`default_nettype wire

/* bench/pcsu_operator.sv */
// keypad operator and reset terminal model for the command unit
`timescale 1ns/100ps
`default_nettype none
module pcsu_operator (
	input  wire logic hclk,
	output logic      enable_pin,
	output logic      reset_pin,
	output logic      reset_key
);
	// idle terminals: drive disabled, key released
	initial begin
		enable_pin = 1'b0;
		reset_pin  = 1'b0;
		reset_key  = 1'b0;
	end
	task automatic set_enable(input logic on);
		@(posedge hclk);
		enable_pin <= on;
		repeat (6) @(posedge hclk);
	endtask
	// key held well past the synchroniser
	task automatic press_key();
		@(posedge hclk);
		reset_key <= 1'b1;
		repeat (6) @(posedge hclk);
		reset_key <= 1'b0;
	endtask
	// one toggle is one drive reset
	task automatic toggle_pin();
		@(posedge hclk);
		reset_pin <= ~reset_pin;
	endtask
endmodule // pcsu_operator
`default_nettype wire

/* bench/pcsu_top_test.sv */
// self-checking bench for the command and security unit
`timescale 1ns/100ps
`default_nettype none
module pcsu_top_test
	import pcsu_pkg::*;
();
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel    = 1'b0;
	logic [31:0] haddr   = 32'h0;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [2:0]  hsize   = 3'h0;
	logic [31:0] hwdata  = 32'h0;
	wire  logic  hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	wire  logic  enable_pin;
	wire  logic  reset_pin;
	wire  logic  reset_key;
	logic        load_defaults;
	logic        defaults_60hz;
	logic        save_params;
	logic [1:0]  op_mode;
	logic        filter_nondefault;
	logic        unlock_fail;
	logic [31:0] rd;
	int          n_mismatch  = 0;
	int          checks_done = 0;
	int          n_load      = 0;
	int          n_save      = 0;

	// 250 MHz clock; single slave so hready is its own hreadyout
	always #2 hclk = ~hclk;
	assign hready = hreadyout;

	pcsu_top pcsu_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .enable_pin(enable_pin),
		.reset_pin(reset_pin), .reset_key(reset_key), .load_defaults(load_defaults),
		.defaults_60hz(defaults_60hz), .save_params(save_params), .op_mode(op_mode),
		.filter_nondefault(filter_nondefault), .unlock_fail(unlock_fail));
	pcsu_operator pcsu_operator_inst (.hclk(hclk), .enable_pin(enable_pin),
		.reset_pin(reset_pin), .reset_key(reset_key));

	// count one-cycle pulses of the action outputs, mid-cycle, clear of the bus tasks
	always @(negedge hclk) begin
		if (load_defaults === 1'b1) n_load++;
		if (save_params === 1'b1) n_save++;
	end

	task automatic wrap_up();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("FAIL %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask
	// wait for hready at the current edge, bounded
	task automatic rdy();
		int i;
		for (i = 0; i < 64 && hreadyout !== 1'b1; i++) @(posedge hclk);
		if (i == 64) begin
			n_mismatch++;
			wrap_up();
		end
	endtask
	// one single word transfer; read data taken at the data phase edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize  <= HSIZE_WORD;
		@(posedge hclk);
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		rdy();
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp}); // okay response
		@(posedge hclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask
	// drive reset by key, terminal or serial request
	task automatic drst(input int k);
		if (k == 0) pcsu_operator_inst.press_key();
		else if (k == 1) pcsu_operator_inst.toggle_pin();
		else wr(OFF_RSTREQ, RST_REQ_CODE);
		repeat (12) @(posedge hclk);
	endtask

	task automatic t_reset();
		chk("op_mode", 32'h1, {30'h0, op_mode});
		chk("filter", 32'h0, {31'h0, filter_nondefault});
		rdchk("access", OFF_ACCESS, 32'h5);
		rdchk("level", OFF_LEVEL, 32'h0);
	endtask
	task automatic t_levels();
		logic [3:0] acc [6] = '{4'h5, 4'hf, 4'h1, 4'h3, 4'h0, 4'h0};
		for (int l = 0; l < 6; l++) begin
			wr(OFF_LEVEL, 32'(l));
			rdchk("access", OFF_ACCESS, {28'h0, acc[l]});
		end
		wr(OFF_CTRL, 32'h4);
		wr(OFF_ACTION, ACT_SHOW_ND);
		chk("filter lvl5", 32'h0, {31'h0, filter_nondefault});
		wr(OFF_LEVEL, 32'h1);
		rdchk("level locked", OFF_LEVEL, 32'h0);
		wr(OFF_CTRL, 32'h0);
		rdchk("level refused", OFF_LEVEL, 32'h5);
		wr(OFF_LEVEL, 32'h1);
	endtask
	task automatic t_modes();
		logic [1:0] m [3] = '{MODE_RFI, MODE_RFS, MODE_OPEN_LOOP};
		int n0;
		for (int i = 0; i < 3; i++) begin
			n0 = n_load;
			wr(OFF_ACTION, (i == 1) ? ACT_MODE_60 : ACT_MODE_50);
			wr(OFF_MODE, {30'h0, m[i]});
			drst(i);
			chk("loads", 32'(n0 + 1), 32'(n_load));
			chk("op_mode", {30'h0, m[i]}, {30'h0, op_mode});
			chk("60hz", (i == 1) ? 32'h1 : 32'h0, {31'h0, defaults_60hz});
		end
		n0 = n_load;
		wr(OFF_ACTION, ACT_MODE_50);
		drst(2);
		chk("loads same", 32'(n0), 32'(n_load));
		rdchk("level kept", OFF_LEVEL, 32'h1);
		rdchk("action", OFF_ACTION, 32'h0);
	endtask
	task automatic t_restore();
		int n0;
		int s0;
		n0 = n_load;
		s0 = n_save;
		pcsu_operator_inst.set_enable(1'b1);
		wr(OFF_CTRL, 32'h1);
		wr(OFF_ACTION, ACT_DEF_50);
		drst(0);
		chk("loads enabled", 32'(n0), 32'(n_load));
		pcsu_operator_inst.set_enable(1'b0);
		wr(OFF_ACTION, ACT_DEF_60);
		drst(1);
		chk("loads", 32'(n0 + 1), 32'(n_load));
		chk("saves", 32'(s0 + 1), 32'(n_save));
		chk("60hz", 32'h1, {31'h0, defaults_60hz});
		rdchk("level kept", OFF_LEVEL, 32'h1);
		wr(OFF_CTRL, 32'h0);
	endtask
	task automatic t_save();
		int s0;
		s0 = n_save;
		wr(OFF_ACTION, ACT_SAVE);
		drst(2);
		chk("saves", 32'(s0 + 1), 32'(n_save));
		rdchk("action", OFF_ACTION, 32'h0);
		wr(OFF_CTRL, 32'h2);
		wr(OFF_ACTION, ACT_SAVE);
		drst(0);
		chk("saves uv", 32'(s0 + 1), 32'(n_save));
		wr(OFF_ACTION, ACT_SAVE_UV);
		drst(0);
		chk("saves uv", 32'(s0 + 2), 32'(n_save));
		wr(OFF_CTRL, 32'h28);
		wr(OFF_CTRL, 32'h20);
		chk("saves adv", 32'(s0 + 2), 32'(n_save));
		wr(OFF_CTRL, 32'h18);
		wr(OFF_CTRL, 32'h10);
		chk("saves basic", 32'(s0 + 3), 32'(n_save));
		wr(OFF_CTRL, 32'h0);
	endtask
	task automatic t_filter();
		wr(OFF_ACTION, ACT_SHOW_ND);
		repeat (2) @(posedge hclk);
		chk("filter on", 32'h1, {31'h0, filter_nondefault});
		wr(OFF_ACTION, ACT_NONE);
		repeat (2) @(posedge hclk);
		chk("filter off", 32'h0, {31'h0, filter_nondefault});
	endtask
	task automatic t_secure();
		wr(OFF_CODE, CODE_MAX);
		rdchk("access armed", OFF_ACCESS, 32'hf);
		drst(0);
		rdchk("code hidden", OFF_CODE, 32'h0);
		rdchk("access locked", OFF_ACCESS, 32'h3);
		wr(OFF_LEVEL, 32'h0);
		rdchk("level", OFF_LEVEL, 32'h0);
		wr(OFF_LEVEL, 32'h1);
		wr(OFF_ACTION, ACT_SHOW_ND);
		chk("filter locked", 32'h0, {31'h0, filter_nondefault});
		wr(OFF_UNLOCK, 32'h1);
		chk("fail", 32'h1, {31'h0, unlock_fail});
		wr(OFF_UNLOCK, CODE_MAX);
		chk("fail", 32'h0, {31'h0, unlock_fail});
		rdchk("access open", OFF_ACCESS, 32'hf);
		wr(OFF_CODE, 32'h0);
		drst(0);
		rdchk("access off", OFF_ACCESS, 32'hf);
	endtask

	// reset for 16 cycles, then the scenarios in turn
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_levels();
		t_modes();
		t_restore();
		t_save();
		t_filter();
		t_secure();
		wrap_up();
	end
endmodule // pcsu_top_test
`default_nettype wire
